/* design/rws_sequencer.sv */
// Purpose: Reset and wake-up sequencer of the clock and state controller.
// Assumes: One clock; the crystal is sampled as a pin and its rising edge is a tick enable.
// Notes:   Power-on reset clears reset output and clock enable with no clock edge.
`default_nettype none

module rws_sequencer
	import rws_pkg::*;
#(
	parameter int OSC_CYCLES = OSC_STABLE_CYCLES, // Fast oscillator settle, clk cycles
	parameter int PLL_CYCLES = PLL_LOCK_CYCLES,   // PLL lock wait, clk cycles
	parameter int HZ_DIV     = XTAL_PER_HZ        // Crystal ticks per 1 Hz period
) (
	input  wire logic clk,                      // 250 MHz system clock
	input  wire logic rst_n,                    // Synchronous reset, active low
	input  wire logic slow_crystal_clock,       // 32.768 kHz crystal clock pin
	input  wire logic power_on_reset_in_n,      // Power-on reset pin, active low
	input  wire logic user_reset_in_n,          // User reset pin, active low
	input  wire logic power_fail_in_n,          // Power fail pin, active low
	input  wire logic wake_request,             // Wake request pin, active high
	input  wire logic battery_good,             // Battery good pin
	input  wire logic external_power_present_n, // External power pin, active low
	output logic      system_reset_out_n,       // System reset, active low
	output logic      osc_clock_enable,         // Fast oscillator enable
	output logic      fast_clock_ready,         // Fast oscillator settled
	output logic      pll_clock_ready,          // PLL outputs usable
	output logic      supply_ok                 // Last sampled supply state
);

	localparam int CW = $clog2((OSC_CYCLES > PLL_CYCLES ? OSC_CYCLES : PLL_CYCLES) + 1);
	localparam int HW = $clog2(HZ_DIV + 1);

	// ----------------------------------------------------------------
	// Tick counter helper
	// ----------------------------------------------------------------
	function automatic logic [2:0] sat_count(input logic [2:0] cnt, input logic hold);
		logic [2:0] r;
		r = 3'h0;
		if (hold) begin
			r = (cnt == 3'h7) ? cnt : cnt + 3'h1;
		end
		return r;
	endfunction : sat_count

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	rws_pins_s pins_raw;
	rws_pins_s meta_q;
	rws_pins_s sync_q;
	logic      xtal_prev_q;

	assign pins_raw = '{xtal: slow_crystal_clock, user_rst_n: user_reset_in_n,
		pwr_fail_n: power_fail_in_n, wake: wake_request, batt_good: battery_good,
		ext_pwr_n: external_power_present_n, por_n: power_on_reset_in_n};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q      <= SYNC_RESET;
			sync_q      <= SYNC_RESET;
			xtal_prev_q <= 1'b0;
		end else begin
			meta_q      <= pins_raw;
			sync_q      <= meta_q;
			xtal_prev_q <= sync_q.xtal;
		end
	end

	wire logic xtal_tick = sync_q.xtal & ~xtal_prev_q;
	wire logic por_ok    = sync_q.por_n;

	// ----------------------------------------------------------------
	// Trigger filters, counted in crystal ticks
	// ----------------------------------------------------------------
	logic [2:0] ur_cnt_q, pf_cnt_q, wk_cnt_q, pf_pulse_q;
	logic [2:0] ur_cnt_d, pf_cnt_d, wk_cnt_d, pf_pulse_d;

	assign ur_cnt_d = xtal_tick ? sat_count(ur_cnt_q, ~sync_q.user_rst_n) : ur_cnt_q;
	assign pf_cnt_d = xtal_tick ? sat_count(pf_cnt_q, ~sync_q.pwr_fail_n) : pf_cnt_q;
	assign wk_cnt_d = xtal_tick ? sat_count(wk_cnt_q, sync_q.wake) : wk_cnt_q;

	// Release clears the count on the next tick, so the reset lifts within 0..2 ticks
	wire logic user_hold = ur_cnt_q >= ASSERT_TICKS;
	wire logic pf_hold   = pf_cnt_q >= ASSERT_TICKS;
	wire logic pf_hit    = xtal_tick && pf_cnt_d == ASSERT_TICKS
		&& pf_cnt_q != ASSERT_TICKS;

	// One pulse per power-fail episode; a long low does not hold reset
	always_comb begin
		pf_pulse_d = pf_pulse_q;
		if (pf_hit) begin
			pf_pulse_d = PF_PULSE_TICKS;
		end else if (xtal_tick && pf_pulse_q != 3'h0) begin
			pf_pulse_d = pf_pulse_q - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ur_cnt_q   <= 3'h0;
			pf_cnt_q   <= 3'h0;
			wk_cnt_q   <= 3'h0;
			pf_pulse_q <= 3'h0;
		end else begin
			ur_cnt_q   <= ur_cnt_d;
			pf_cnt_q   <= pf_cnt_d;
			wk_cnt_q   <= wk_cnt_d;
			pf_pulse_q <= pf_pulse_d;
		end
	end

	wire logic kill    = user_hold || pf_hold || !por_ok;
	wire logic rst_req = user_hold || pf_pulse_q != 3'h0 || !por_ok;

	// ----------------------------------------------------------------
	// 1 Hz guard and supply sampling
	// ----------------------------------------------------------------
	logic [HW-1:0] hz_pre_q;
	logic [1:0]    hz_cnt_q;
	logic          supply_ok_q;
	logic          ur_gap_q;
	wire logic     hz_tick  = xtal_tick && hz_pre_q == HW'(HZ_DIV - 1);
	wire logic     guard_rs = !por_ok || pf_hold;

	always_ff @(posedge clk) begin
		if (!rst_n || guard_rs) begin
			hz_pre_q    <= '0;
			hz_cnt_q    <= 2'h0;
			supply_ok_q <= 1'b0;
		end else if (xtal_tick) begin
			hz_pre_q <= hz_tick ? '0 : hz_pre_q + HW'(1);
			if (hz_tick) begin
				hz_cnt_q    <= (hz_cnt_q == HZ_GUARD) ? hz_cnt_q : hz_cnt_q + 2'h1;
				supply_ok_q <= sync_q.batt_good | ~sync_q.ext_pwr_n;
			end
		end
	end

	// Wake is held off for a couple of ticks after a user reset lifts
	always_ff @(posedge clk) begin
		if (!rst_n || user_hold) begin
			ur_gap_q <= 1'b1;
		end else if (xtal_tick && ur_cnt_q == 3'h0) begin
			ur_gap_q <= 1'b0;
		end
	end

	wire logic wake_ok = hz_cnt_q == HZ_GUARD && supply_ok_q && !ur_gap_q
		&& !kill;
	wire logic wake_seen = xtal_tick && wk_cnt_d >= ASSERT_TICKS;

	// ----------------------------------------------------------------
	// Standby to Run sequence
	// ----------------------------------------------------------------
	rws_state_e    state_q, state_d;
	logic [CW-1:0] cyc_q, cyc_d;

	always_comb begin
		state_d = state_q;
		cyc_d   = cyc_q + CW'(1);
		unique case (state_q)
			RWS_STANDBY: begin
				cyc_d = '0;
				if (wake_ok && wake_seen) begin
					state_d = RWS_OSC_WAIT;
				end
			end
			RWS_OSC_WAIT: begin
				if (cyc_q == CW'(OSC_CYCLES - 1)) begin
					state_d = RWS_PLL_WAIT;
					cyc_d   = '0;
				end
			end
			RWS_PLL_WAIT: begin
				if (cyc_q == CW'(PLL_CYCLES - 1)) begin
					state_d = RWS_RUN;
					cyc_d   = '0;
				end
			end
			RWS_RUN: begin
				cyc_d = '0;
			end
		endcase
		if (kill) begin
			state_d = RWS_STANDBY;
			cyc_d   = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= RWS_STANDBY;
			cyc_q   <= '0;
		end else begin
			state_q <= state_d;
			cyc_q   <= cyc_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Power-on reset clears these without a clock; release follows the synchronised pin
	always_ff @(posedge clk or negedge power_on_reset_in_n) begin
		if (!power_on_reset_in_n) begin
			system_reset_out_n <= 1'b0;
			osc_clock_enable   <= 1'b0;
		end else if (!rst_n) begin
			system_reset_out_n <= 1'b0;
			osc_clock_enable   <= 1'b0;
		end else begin
			system_reset_out_n <= ~rst_req;
			osc_clock_enable   <= state_d != RWS_STANDBY;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fast_clock_ready <= 1'b0;
			pll_clock_ready  <= 1'b0;
			supply_ok        <= 1'b0;
		end else begin
			fast_clock_ready <= state_d == RWS_PLL_WAIT || state_d == RWS_RUN;
			pll_clock_ready  <= state_d == RWS_RUN;
			supply_ok        <= supply_ok_q;
		end
	end

endmodule : rws_sequencer

`default_nettype wire

/* design/rws_pkg.sv */
// Purpose: Constants and types for the reset and wake-up sequencer.
// Assumes: System clock of 250 MHz; the crystal and all board signals are asynchronous pins.
// Notes:   All tick counts are in slow crystal periods unless named as cycles.
//
// Contract
// - Battery-good and external-power are sampled over the two 1 Hz periods before wake.
// - PLLs get 250 us to lock once the fast oscillator is stable.
// - Fast oscillator gets up to 2.5 ms after wake before its clock is used.
// - System reset follows power-on reset asynchronously, within 30 ns both ways; release here goes through the two-flop synchroniser, within 3 clk cycles.
// - Oscillator enable rises 2 to 4 crystal periods after wake request.
// - User reset low drives system reset low within 2 to 4 crystal periods.
// - User reset release frees system reset within 0 to 2 crystal periods.
// - User reset low drops oscillator enable within 2 to 4 crystal periods.
// - Power fail low drives system reset low within 2 to 4 crystal periods.
// - Power-fail reset pulse lasts typically 2 crystal periods.
// - Power fail low drops oscillator enable within 2 to 4 crystal periods.
`default_nettype none

package rws_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 4;
	localparam int OSC_STABLE_NS       = 2500000;
	localparam int PLL_LOCK_NS         = 250000;
	localparam int OSC_STABLE_CYCLES   = OSC_STABLE_NS / CLK_PERIOD_NS;
	localparam int PLL_LOCK_CYCLES     = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XTAL_PER_HZ         = 32768;
	// Third low tick: the first tick may fall just after the pin edge, so two would undercut
	localparam logic [2:0] ASSERT_TICKS   = 3'h3;
	localparam logic [2:0] PF_PULSE_TICKS = 3'h2;
	localparam logic [1:0] HZ_GUARD       = 2'h2;
	localparam logic [6:0] SYNC_RESET     = 7'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RWS_STANDBY  = 2'b00,
		RWS_OSC_WAIT = 2'b01,
		RWS_PLL_WAIT = 2'b10,
		RWS_RUN      = 2'b11
	} rws_state_e;

	typedef struct packed {
		logic xtal;
		logic user_rst_n;
		logic pwr_fail_n;
		logic wake;
		logic batt_good;
		logic ext_pwr_n;
		logic por_n;
	} rws_pins_s;

endpackage : rws_pkg

`default_nettype wire

/* tb/rws_props.sv */
// Purpose: Port-level assertions for the reset and wake-up sequencer.
// Assumes: Crystal period is 8 clk cycles in simulation.
// Notes:   Upper bounds allow for the two-flop synchroniser.
`default_nettype none
module rws_props #(
	parameter int OSC_CYCLES = 20,
	parameter int PLL_CYCLES = 10
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic power_on_reset_in_n, // Pin
	input wire logic user_reset_in_n, // Pin
	input wire logic power_fail_in_n, // Pin
	input wire logic wake_request, // Pin
	input wire logic system_reset_out_n, // Output
	input wire logic osc_clock_enable, // Output
	input wire logic fast_clock_ready, // Output
	input wire logic pll_clock_ready, // Output
	input wire logic supply_ok // Output
);
	localparam int OSC_LO = OSC_CYCLES - 1;
	localparam int OSC_HI = OSC_CYCLES + 1;
	localparam int PLL_LO = PLL_CYCLES - 1;
	localparam int PLL_HI = PLL_CYCLES + 1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !power_on_reset_in_n);
	sequence s_osc_on; $rose(osc_clock_enable); endsequence
	sequence s_fast_on; $rose(fast_clock_ready); endsequence
	AST_USR_RST: assert property ($fell(user_reset_in_n) |-> ##[16:36] !system_reset_out_n)
		else $error("user reset did not reach reset output");
	AST_USR_REL: assert property ($rose(user_reset_in_n) |-> ##[1:20] system_reset_out_n)
		else $error("reset output not released");
	AST_USR_OSC: assert property ($fell(user_reset_in_n) |-> ##[16:36] !osc_clock_enable)
		else $error("oscillator enable kept on user reset");
	AST_PF_RST: assert property ($fell(power_fail_in_n) |-> ##[16:36] !system_reset_out_n)
		else $error("power fail did not reach reset output");
	AST_PF_PULSE: assert property ($fell(system_reset_out_n) && user_reset_in_n
		|-> !system_reset_out_n[*8] ##[1:24] system_reset_out_n)
		else $error("power fail pulse width wrong");
	AST_PF_OSC: assert property ($fell(power_fail_in_n) |-> ##[16:36] !osc_clock_enable)
		else $error("oscillator enable kept on power fail");
	AST_WAKE_OSC: assert property (s_osc_on |-> $past(wake_request, 16))
		else $error("oscillator enable rose too early");
	AST_SUPPLY: assert property (s_osc_on |-> supply_ok)
		else $error("wake taken with bad supply");
	AST_FAST: assert property (s_osc_on |-> ##[OSC_LO:OSC_HI] $rose(fast_clock_ready))
		else $error("fast clock ready time wrong");
	AST_PLL: assert property (s_fast_on |-> ##[PLL_LO:PLL_HI] $rose(pll_clock_ready))
		else $error("pll ready time wrong");
	AST_POR: assert property (disable iff (!rst_n)
		!power_on_reset_in_n |-> !system_reset_out_n && !osc_clock_enable)
		else $error("power-on reset not followed");
endmodule : rws_props
`default_nettype wire

/* tb/rws_board.sv */
// Purpose: Board model: crystal, power-on supervisor and supply pins.
// Assumes: Crystal half period 16 ns, i.e. 8 clk cycles a period.
// Notes:   Crystal runs free, as a real oscillator does.
`default_nettype none
module rws_board (
	input  wire logic por_req,                  // Bench asks for power-on reset
	input  wire logic supply_bad,               // Bench removes battery and mains
	output logic      slow_crystal_clock,       // Crystal
	output logic      power_on_reset_in_n,      // Supervisor output
	output logic      battery_good,             // Battery pin
	output logic      external_power_present_n  // Mains pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic osc_stable;
	initial begin
		slow_crystal_clock = 1'b0;
		forever #16 slow_crystal_clock = ~slow_crystal_clock;
	end
	initial begin
		osc_stable = 1'b0;
		repeat (10) @(posedge slow_crystal_clock);
		osc_stable = 1'b1;
	end
	assign power_on_reset_in_n = osc_stable && !por_req;
	assign battery_good = !supply_bad;
	assign external_power_present_n = supply_bad;
endmodule : rws_board
`default_nettype wire

/* tb/rws_sequencer_bench.sv */
// Purpose: Self-checking bench for the reset and wake-up sequencer.
// Assumes: Short counts: OSC 20, PLL 10, 8 crystal ticks a 1 Hz period.
// Notes:   Pins change at the falling clk edge.
`default_nettype none
module rws_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, por_req, supply_bad, user_reset_in_n, power_fail_in_n, wake_request;
	wire logic xtal, por_n, batt, ext_n, rst_out_n, osc_en, fast_rdy, pll_rdy, sup_ok;
	wire logic [3:0] outs = {pll_rdy, fast_rdy, osc_en, rst_out_n};
	int num_errors, tests_run, n;
	rws_board rws_board_inst (.por_req(por_req), .supply_bad(supply_bad),
		.slow_crystal_clock(xtal), .power_on_reset_in_n(por_n), .battery_good(batt),
		.external_power_present_n(ext_n));
	rws_sequencer #(.OSC_CYCLES(20), .PLL_CYCLES(10), .HZ_DIV(8)) rws_sequencer_inst (
		.clk(clk), .rst_n(rst_n), .slow_crystal_clock(xtal), .power_on_reset_in_n(por_n),
		.user_reset_in_n(user_reset_in_n), .power_fail_in_n(power_fail_in_n),
		.wake_request(wake_request), .battery_good(batt), .external_power_present_n(ext_n),
		.system_reset_out_n(rst_out_n), .osc_clock_enable(osc_en),
		.fast_clock_ready(fast_rdy), .pll_clock_ready(pll_rdy), .supply_ok(sup_ok));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task complete_run;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	task chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task waitfor(input int sel, input logic v);
		n = 0;
		while (outs[sel] !== v) begin
			@(negedge clk);
			n++;
			if (n > 2000) begin
				chk(1'b0, "timeout");
				complete_run;
			end
		end
	endtask : waitfor
	task ticks(input int k);
		repeat (k) @(posedge xtal);
		@(negedge clk);
	endtask : ticks
	task do_wake(input bit ok);
		wake_request = 1'b1;
		if (ok) begin
			waitfor(1, 1'b1);
			chk(n >= 16 && n <= 36, "wake to enable");
			chk(sup_ok === 1'b1, "supply flag");
			waitfor(2, 1'b1);
			chk(n >= 19 && n <= 22, "fast ready");
			waitfor(3, 1'b1);
			chk(n >= 9 && n <= 12, "pll ready");
		end else begin
			repeat (48) @(negedge clk);
			chk(osc_en === 1'b0 && sup_ok === 1'b0, "wake not refused");
		end
		ticks(1);
		wake_request = 1'b0;
		$display("wake test done");
	endtask : do_wake
	task t_user;
		user_reset_in_n = 1'b0;
		waitfor(0, 1'b0);
		chk(n >= 16 && n <= 36, "user reset delay");
		chk(outs === 4'h0, "enable and ready not dropped");
		ticks(5);
		user_reset_in_n = 1'b1;
		waitfor(0, 1'b1);
		chk(n <= 20, "user release delay");
		ticks(2);
		do_wake(1'b1);
		$display("user reset test done");
	endtask : t_user
	task t_pfail;
		power_fail_in_n = 1'b0;
		waitfor(0, 1'b0);
		chk(n >= 16 && n <= 36, "power fail delay");
		chk(osc_en === 1'b0, "enable not dropped");
		waitfor(0, 1'b1);
		chk(n >= 8 && n <= 32, "pulse width");
		ticks(3);
		power_fail_in_n = 1'b1;
		supply_bad = 1'b1;
		ticks(20);
		do_wake(1'b0);
		supply_bad = 1'b0;
		ticks(20);
		do_wake(1'b1);
		$display("power fail test done");
	endtask : t_pfail
	task t_por;
		por_req = 1'b1;
		#1 chk(rst_out_n === 1'b0 && osc_en === 1'b0, "async por");
		@(negedge clk);
		por_req = 1'b0;
		waitfor(0, 1'b1);
		chk(n <= 4, "por release");
		$display("power-on test done");
	endtask : t_por
	initial begin
		{num_errors, tests_run} = '0;
		{rst_n, por_req, supply_bad, wake_request} = 4'h0;
		{user_reset_in_n, power_fail_in_n} = 2'h3;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		ticks(12);
		chk(rst_out_n === 1'b1, "reset out after por");
		ticks(20);
		do_wake(1'b1);
		t_user;
		t_pfail;
		t_por;
		complete_run;
	end
endmodule : rws_sequencer_bench
bind rws_sequencer rws_props #(.OSC_CYCLES(OSC_CYCLES), .PLL_CYCLES(PLL_CYCLES)) rws_props_inst (
	.clk(clk), .rst_n(rst_n), .power_on_reset_in_n(power_on_reset_in_n),
	.user_reset_in_n(user_reset_in_n), .power_fail_in_n(power_fail_in_n),
	.wake_request(wake_request), .system_reset_out_n(system_reset_out_n),
	.osc_clock_enable(osc_clock_enable), .fast_clock_ready(fast_clock_ready),
	.pll_clock_ready(pll_clock_ready), .supply_ok(supply_ok));
`default_nettype wire
